// file: pkg/orl_pkg.sv
package orl_pkg;

    // Gate function codes
    typedef enum logic [2:0] {
        ORL_FN_OR      = 3'h0,
        ORL_FN_AND     = 3'h1,
        ORL_FN_NOR     = 3'h2,
        ORL_FN_NAND    = 3'h3,
        ORL_FN_DISABLE = 3'h4
    } orl_fn_t;

    // Dropout policy codes
    typedef enum logic [1:0] {
        ORL_DO_LATCHED   = 2'h0,
        ORL_DO_UNLATCHED = 2'h1,
        ORL_DO_OFFDELAY  = 2'h2
    } orl_dropout_t;

    // Contact input role codes
    typedef enum logic [3:0] {
        ORL_CI_USER        = 4'h0,
        ORL_CI_BKR_52A     = 4'h1,
        ORL_CI_BKR_52B     = 4'h2,
        ORL_CI_REM_OPEN    = 4'h3,
        ORL_CI_REM_CLOSE   = 4'h4,
        ORL_CI_REM_RESET   = 4'h5,
        ORL_CI_LOG_TRIG    = 4'h6,
        ORL_CI_DEMAND_SYNC = 4'h7,
        ORL_CI_SET_ONE     = 4'h8,
        ORL_CI_SET_TWO     = 4'h9,
        ORL_CI_BF_INIT     = 4'ha,
        ORL_CI_BKR_TROUBLE = 4'hb
    } orl_role_t;

    localparam int ORL_NUM_OUT  = 4;
    localparam int ORL_NUM_SLOT = 4;
    localparam int ORL_NUM_CIN  = 8;
    localparam int ORL_NUM_SRC  = 16;
    localparam int ORL_SEL_W    = 4;
    localparam int ORL_DLY_W    = 6;
    localparam logic [5:0] ORL_DLY_MAX = 6'h3c;

    // Logic input source select codes; 0 means slot unused
    localparam logic [3:0] ORL_SRC_UNUSED     = 4'h0;
    localparam logic [3:0] ORL_SRC_ALL_PROT   = 4'h1;
    localparam logic [3:0] ORL_SRC_OPEN_BKR   = 4'h2;
    localparam logic [3:0] ORL_SRC_BF_TRIP    = 4'h3;
    localparam logic [3:0] ORL_SRC_CLOSE_BKR  = 4'h4;

    // Register index map (word addresses)
    localparam logic [7:0] ORL_A_FN0     = 8'h00;
    localparam logic [7:0] ORL_A_DO0     = 8'h04;
    localparam logic [7:0] ORL_A_DLY0    = 8'h08;
    localparam logic [7:0] ORL_A_SLOT0   = 8'h0c;
    localparam logic [7:0] ORL_A_MON     = 8'h10;
    localparam logic [7:0] ORL_A_ROLE0   = 8'h20;
    localparam logic [7:0] ORL_A_STATUS  = 8'h28;
    localparam logic [7:0] ORL_A_RESET   = 8'h29;

    // Monitor enables: bit 0 trip coil, bit 1 close coil
    localparam logic [1:0] ORL_MON_RST = 2'h1;

    // Defaults per channel
    localparam logic [2:0] ORL_FN_RST [ORL_NUM_OUT] =
        '{3'h0, 3'h4, 3'h0, 3'h4};
    localparam logic [1:0] ORL_DO_RST [ORL_NUM_OUT] =
        '{2'h2, 2'h1, 2'h0, 2'h1};
    localparam logic [5:0] ORL_DLY_RST [ORL_NUM_OUT] =
        '{6'h05, 6'h00, 6'h00, 6'h00};
    localparam logic [15:0] ORL_SLOT_RST [ORL_NUM_OUT] =
        '{16'h0021, 16'h0000, 16'h0003, 16'h0000};
    localparam logic [3:0] ORL_ROLE_RST [ORL_NUM_CIN] =
        '{4'h1, 4'h2, 4'ha, 4'hb, 4'h3, 4'h4, 4'h5, 4'h0};

endpackage

// file: rtl/orl_output_logic.sv
`timescale 1ns/1ps
module orl_output_logic
    import orl_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // Power-line cycle tick, one core_clk pulse per cycle
    input  wire logic                    line_cycle_tick,
    // Internal logic sources, bit 0 is unused and ignored
    input  wire logic [ORL_NUM_SRC-1:0]  logic_src,
    // Field contact inputs
    input  wire logic [ORL_NUM_CIN-1:0]  contact_in,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // Relay outputs: trip one, trip two, aux three, aux four
    output logic      [ORL_NUM_OUT-1:0]  relay_out,
    output logic                         trip_coil_mon_en,
    output logic                         close_coil_mon_en,
    // Contact input role outputs
    output logic      [ORL_NUM_CIN-1:0]  bkr_52a,
    output logic                         bkr_52a_any,
    output logic                         bkr_52b_any,
    output logic                         remote_open,
    output logic                         remote_close,
    output logic                         remote_reset,
    output logic                         logging_trigger,
    output logic                         demand_sync,
    output logic                         set_select_one,
    output logic                         set_select_two,
    output logic                         breaker_failure_initiate,
    output logic                         breaker_trouble
);

    // Settings
    logic [2:0]  fn_r     [ORL_NUM_OUT];
    logic [2:0]  fn_nxt   [ORL_NUM_OUT];
    logic [1:0]  do_r     [ORL_NUM_OUT];
    logic [1:0]  do_nxt   [ORL_NUM_OUT];
    logic [5:0]  dly_r    [ORL_NUM_OUT];
    logic [5:0]  dly_nxt  [ORL_NUM_OUT];
    logic [15:0] slot_r   [ORL_NUM_OUT];
    logic [15:0] slot_nxt [ORL_NUM_OUT];
    logic [3:0]  role_r   [ORL_NUM_CIN];
    logic [3:0]  role_nxt [ORL_NUM_CIN];
    logic [1:0]  mon_r;
    logic [1:0]  mon_nxt;
    logic        sw_reset_r;
    logic        sw_reset_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Channel state
    logic [ORL_NUM_OUT-1:0] out_r;
    logic [ORL_NUM_OUT-1:0] out_nxt;
    logic [5:0]  cnt_r    [ORL_NUM_OUT];
    logic [5:0]  cnt_nxt  [ORL_NUM_OUT];

    // Role decode
    logic [ORL_NUM_CIN-1:0] role_hit_nxt [12];
    logic [ORL_NUM_CIN-1:0] role_hit_r   [12];

    logic [ORL_NUM_OUT-1:0] gate_res;
    logic                   latch_clear;

    always_comb
    begin
        fn_nxt       = fn_r;
        do_nxt       = do_r;
        dly_nxt      = dly_r;
        slot_nxt     = slot_r;
        role_nxt     = role_r;
        mon_nxt      = mon_r;
        sw_reset_nxt = 1'b0;
        rdata_nxt    = 32'h0;
        if (reg_wr)
        begin
            for (int i = 0; i < ORL_NUM_OUT; i++)
            begin
                if (reg_addr == ORL_A_FN0 + 8'(i))
                begin
                    // Illegal codes fold to disabled
                    if (reg_wdata[2:0] > ORL_FN_DISABLE)
                        fn_nxt[i] = ORL_FN_DISABLE;
                    else
                        fn_nxt[i] = reg_wdata[2:0];
                end
                if (reg_addr == ORL_A_DO0 + 8'(i))
                begin
                    if (reg_wdata[1:0] > ORL_DO_OFFDELAY)
                        do_nxt[i] = ORL_DO_UNLATCHED;
                    else
                        do_nxt[i] = reg_wdata[1:0];
                end
                if (reg_addr == ORL_A_DLY0 + 8'(i))
                begin
                    // Saturate at the top of the delay range
                    if (reg_wdata[5:0] > ORL_DLY_MAX)
                        dly_nxt[i] = ORL_DLY_MAX;
                    else
                        dly_nxt[i] = reg_wdata[5:0];
                end
                if (reg_addr == ORL_A_SLOT0 + 8'(i))
                    slot_nxt[i] = reg_wdata[15:0];
            end
            for (int k = 0; k < ORL_NUM_CIN; k++)
            begin
                if (reg_addr == ORL_A_ROLE0 + 8'(k))
                begin
                    if (reg_wdata[3:0] > ORL_CI_BKR_TROUBLE)
                        role_nxt[k] = ORL_CI_USER;
                    else
                        role_nxt[k] = reg_wdata[3:0];
                end
            end
            if (reg_addr == ORL_A_MON)
                mon_nxt = reg_wdata[1:0];
            if (reg_addr == ORL_A_RESET)
                sw_reset_nxt = reg_wdata[0];
        end
        // Read data stands one cycle, zero otherwise
        if (reg_rd)
        begin
            for (int i = 0; i < ORL_NUM_OUT; i++)
            begin
                if (reg_addr == ORL_A_FN0 + 8'(i))
                    rdata_nxt = {29'h0, fn_r[i]};
                if (reg_addr == ORL_A_DO0 + 8'(i))
                    rdata_nxt = {30'h0, do_r[i]};
                if (reg_addr == ORL_A_DLY0 + 8'(i))
                    rdata_nxt = {26'h0, dly_r[i]};
                if (reg_addr == ORL_A_SLOT0 + 8'(i))
                    rdata_nxt = {16'h0, slot_r[i]};
            end
            for (int k = 0; k < ORL_NUM_CIN; k++)
                if (reg_addr == ORL_A_ROLE0 + 8'(k))
                    rdata_nxt = {28'h0, role_r[k]};
            if (reg_addr == ORL_A_MON)
                rdata_nxt = {30'h0, mon_r};
            if (reg_addr == ORL_A_STATUS)
                rdata_nxt = {24'h0, contact_in[7:4], out_r};
        end
    end

    // Gate evaluation over the four slots
    always_comb
    begin
        logic [3:0] sel;
        logic       any_used;
        logic       or_v;
        logic       and_v;
        sel      = 4'h0;
        any_used = 1'b0;
        or_v     = 1'b0;
        and_v    = 1'b1;
        gate_res = '0;
        for (int i = 0; i < ORL_NUM_OUT; i++)
        begin
            any_used = 1'b0;
            or_v     = 1'b0;
            and_v    = 1'b1;
            for (int s = 0; s < ORL_NUM_SLOT; s++)
            begin
                sel = slot_r[i][s*ORL_SEL_W +: ORL_SEL_W];
                if (sel != ORL_SRC_UNUSED)
                begin
                    any_used = 1'b1;
                    or_v     = or_v | logic_src[sel];
                    and_v    = and_v & logic_src[sel];
                end
            end
            // No used slot: AND would be vacuously true, so force idle
            unique case (orl_fn_t'(fn_r[i]))
                ORL_FN_OR:   gate_res[i] = or_v;
                ORL_FN_AND:  gate_res[i] = any_used & and_v;
                ORL_FN_NOR:  gate_res[i] = any_used & ~or_v;
                ORL_FN_NAND: gate_res[i] = any_used & ~and_v;
                default:     gate_res[i] = 1'b0;
            endcase
        end
    end

    // Remote reset contact or software pulse clears latches
    assign latch_clear = sw_reset_r | (|role_hit_r[ORL_CI_REM_RESET]);

    always_comb
    begin
        out_nxt = out_r;
        cnt_nxt = cnt_r;
        for (int i = 0; i < ORL_NUM_OUT; i++)
        begin
            if (gate_res[i])
            begin
                out_nxt[i] = 1'b1;
                cnt_nxt[i] = dly_r[i];
            end
            else
            begin
                unique case (orl_dropout_t'(do_r[i]))
                    ORL_DO_LATCHED:
                        if (latch_clear)
                            out_nxt[i] = 1'b0;
                    ORL_DO_OFFDELAY:
                        // Count line cycles down after clear
                        if (cnt_r[i] == 6'h0)
                            out_nxt[i] = 1'b0;
                        else if (line_cycle_tick)
                            cnt_nxt[i] = cnt_r[i] - 6'h1;
                    default:
                        out_nxt[i] = 1'b0;
                endcase
                if (do_r[i] != ORL_DO_OFFDELAY)
                    cnt_nxt[i] = 6'h0;
            end
            // Disable wins over any held or latched state
            if (fn_r[i] == ORL_FN_DISABLE)
            begin
                out_nxt[i] = 1'b0;
                cnt_nxt[i] = 6'h0;
            end
        end
    end

    // Role hits registered, one clock behind the contact
    always_comb
    begin
        for (int r = 0; r < 12; r++)
            for (int k = 0; k < ORL_NUM_CIN; k++)
                role_hit_nxt[r][k] = contact_in[k] &
                    (role_r[k] == 4'(r));
    end

    // Synchronous reset returns every setting to its default
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fn_r       <= ORL_FN_RST;
            do_r       <= ORL_DO_RST;
            dly_r      <= ORL_DLY_RST;
            slot_r     <= ORL_SLOT_RST;
            role_r     <= ORL_ROLE_RST;
            mon_r      <= ORL_MON_RST;
            sw_reset_r <= 1'b0;
            rdata_r    <= 32'h0;
            out_r      <= '0;
            cnt_r      <= '{default: 6'h0};
            role_hit_r <= '{default: '0};
        end
        else
        begin
            fn_r       <= fn_nxt;
            do_r       <= do_nxt;
            dly_r      <= dly_nxt;
            slot_r     <= slot_nxt;
            role_r     <= role_nxt;
            mon_r      <= mon_nxt;
            sw_reset_r <= sw_reset_nxt;
            rdata_r    <= rdata_nxt;
            out_r      <= out_nxt;
            cnt_r      <= cnt_nxt;
            role_hit_r <= role_hit_nxt;
        end
    end

    // Every output taken from flops, bkr_52a straight from registered hits, the other role flags through an OR of them
    assign reg_rdata                = rdata_r;
    assign relay_out                = out_r;
    assign trip_coil_mon_en         = mon_r[0];
    assign close_coil_mon_en        = mon_r[1];
    assign bkr_52a                  = role_hit_r[ORL_CI_BKR_52A];
    assign bkr_52a_any              = |role_hit_r[ORL_CI_BKR_52A];
    assign bkr_52b_any              = |role_hit_r[ORL_CI_BKR_52B];
    assign remote_open              = |role_hit_r[ORL_CI_REM_OPEN];
    assign remote_close             = |role_hit_r[ORL_CI_REM_CLOSE];
    assign remote_reset             = |role_hit_r[ORL_CI_REM_RESET];
    assign logging_trigger          = |role_hit_r[ORL_CI_LOG_TRIG];
    assign demand_sync              = |role_hit_r[ORL_CI_DEMAND_SYNC];
    assign set_select_one           = |role_hit_r[ORL_CI_SET_ONE];
    assign set_select_two           = |role_hit_r[ORL_CI_SET_TWO];
    assign breaker_failure_initiate = |role_hit_r[ORL_CI_BF_INIT];
    assign breaker_trouble          = |role_hit_r[ORL_CI_BKR_TROUBLE];

endmodule

// file: verification/orl_output_logic_props.sv
`timescale 1ns/1ps
module orl_output_logic_props
    import orl_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Watched ports
    input wire logic [7:0]  contact_in,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0]  relay_out,
    input wire logic        trip_coil_mon_en,
    input wire logic        close_coil_mon_en,
    input wire logic [7:0]  bkr_52a,
    input wire logic        remote_reset
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Shadow settings, so no design internals are needed
    logic [3:0] role_r [8];
    logic [3:0] role_nxt [8];
    logic [2:0] fn_r [4];
    logic [2:0] fn_nxt [4];
    logic [3:0] dis_m;
    logic [7:0] h52a;
    logic [7:0] hrr;
    always_comb
    begin
        role_nxt = role_r;
        fn_nxt   = fn_r;
        if (reg_wr && reg_addr[7:3] == 5'h04)
            role_nxt[reg_addr[2:0]] =
                (reg_wdata[3:0] > 4'hb) ? 4'h0 : reg_wdata[3:0];
        if (reg_wr && reg_addr[7:2] == 6'h00)
            fn_nxt[reg_addr[1:0]] =
                (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
        for (int i = 0; i < 8; i++)
        begin
            h52a[i] = role_r[i] == 4'h1;
            hrr[i]  = role_r[i] == 4'h5;
        end
        for (int i = 0; i < 4; i++)
            dis_m[i] = fn_r[i] == 3'h4;
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            role_r <= '{4'h1, 4'h2, 4'ha, 4'hb, 4'h3, 4'h4, 4'h5, 4'h0};
            fn_r   <= '{3'h0, 3'h4, 3'h0, 3'h4};
        end
        else
        begin
            role_r <= role_nxt;
            fn_r   <= fn_nxt;
        end
    end
    sequence s_mon_wr;
        reg_wr && reg_addr == ORL_A_MON;
    endsequence
    sequence s_no_mon_wr;
        !(reg_wr && reg_addr == ORL_A_MON);
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_status_rd: assert property (reg_rd && reg_addr == ORL_A_STATUS |=>
        reg_rdata[7:0] == {$past(contact_in[7:4]), $past(relay_out)})
        else $error("status read wrong");
    a_mon_write: assert property (s_mon_wr |=>
        trip_coil_mon_en == $past(reg_wdata[0]) &&
        close_coil_mon_en == $past(reg_wdata[1]))
        else $error("monitor enable not taken");
    a_mon_hold: assert property (s_no_mon_wr |=>
        $stable({trip_coil_mon_en, close_coil_mon_en}))
        else $error("monitor enable changed");
    a_mon_reset: assert property ($fell(sys_rst) |->
        trip_coil_mon_en && !close_coil_mon_en)
        else $error("monitor default wrong");
    a_role_52a: assert property (!$past(sys_rst) |->
        bkr_52a == $past(contact_in & h52a))
        else $error("52a role output wrong");
    a_rem_reset: assert property (!$past(sys_rst) |->
        remote_reset == |$past(contact_in & hrr))
        else $error("remote reset output wrong");
    a_disabled_off: assert property (|dis_m |=>
        (relay_out & $past(dis_m)) == 4'h0)
        else $error("disabled output asserted");
endmodule

// file: verification/orl_field_model.sv
`timescale 1ns/1ps
module orl_field_model #(
    parameter int TICK_P = 8
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Contact states wanted by the bench
    input  wire logic [7:0] ci_cmd,
    // Field side
    output logic      [7:0] contact_in,
    output logic            line_cycle_tick
);
    // Line period shrunk to a few clocks to keep runs short
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    always_comb
    begin
        cnt_nxt = (cnt_r == 8'(TICK_P - 1)) ? 8'h0 : cnt_r + 8'h1;
    end
    always_ff @(posedge core_clk)
    begin
        cnt_r           <= sys_rst ? 8'h0 : cnt_nxt;
        line_cycle_tick <= !sys_rst && cnt_nxt == 8'h0;
        contact_in      <= ci_cmd;
    end
endmodule

// file: verification/orl_output_logic_test.sv
`timescale 1ns/1ps
module orl_output_logic_test
    import orl_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [15:0] logic_src = 16'h0;
    logic [7:0]  ci_cmd = 8'h0;
    logic [7:0]  contact_in, bkr_52a;
    logic [31:0] reg_rdata;
    logic [3:0]  relay_out;
    logic        line_cycle_tick, trip_coil_mon_en, close_coil_mon_en;
    logic        bkr_52a_any, bkr_52b_any, remote_open, remote_close;
    logic        remote_reset, logging_trigger, demand_sync;
    logic        set_select_one, set_select_two;
    logic        breaker_failure_initiate, breaker_trouble;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [7:0]  fn_e [4] = '{8'h0, 8'h4, 8'h0, 8'h4};
    logic [7:0]  do_e [4] = '{8'h2, 8'h1, 8'h0, 8'h1};
    logic [7:0]  dly_e [4] = '{8'h5, 8'h0, 8'h0, 8'h0};
    logic [15:0] slot_e [4] = '{16'h21, 16'h0, 16'h3, 16'h0};
    logic [7:0]  rl_e [8] =
        '{8'h1, 8'h2, 8'ha, 8'hb, 8'h3, 8'h4, 8'h5, 8'h0};
    orl_output_logic u_orl_output_logic (
        .core_clk, .sys_rst, .line_cycle_tick, .logic_src, .contact_in,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .relay_out,
        .trip_coil_mon_en, .close_coil_mon_en, .bkr_52a, .bkr_52a_any,
        .bkr_52b_any, .remote_open, .remote_close, .remote_reset,
        .logging_trigger, .demand_sync, .set_select_one, .set_select_two,
        .breaker_failure_initiate, .breaker_trouble);
    orl_field_model #(.TICK_P(8)) u_orl_field_model (
        .core_clk, .sys_rst, .ci_cmd, .contact_in, .line_cycle_tick);
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic drive(input logic [15:0] s, input logic [7:0] c);
        @(posedge core_clk);
        logic_src <= s;
        ci_cmd    <= c;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    function automatic logic gate(input int f, input int p);
        case (f)
            0: return p != 0;
            1: return p == 3;
            2: return p == 0;
            3: return p != 3;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rdc(ORL_A_FN0 + 8'(i), fn_e[i]);
            rdc(ORL_A_DO0 + 8'(i), do_e[i]);
            rdc(ORL_A_DLY0 + 8'(i), dly_e[i]);
            rdc(ORL_A_SLOT0 + 8'(i), slot_e[i]);
        end
        for (int i = 0; i < 8; i++)
            rdc(ORL_A_ROLE0 + 8'(i), rl_e[i]);
        rdc(ORL_A_MON, 32'h1);
        rdc(8'h3f, 32'h0);
        $display("defaults done");
        drive(16'h2, 8'h0);
        cyc(2);
        chk(relay_out[0], 1'b1);
        drive(16'h0, 8'h0);
        repeat (4) @(posedge line_cycle_tick);
        cyc(2);
        chk(relay_out[0], 1'b1);
        @(posedge line_cycle_tick);
        cyc(2);
        chk(relay_out[0], 1'b0);
        wr(ORL_A_DLY0, 32'h3f);
        rdc(ORL_A_DLY0, 32'h3c);
        wr(ORL_A_DO0, 32'h1);
        drive(16'h4, 8'h0);
        cyc(2);
        chk(relay_out[0], 1'b1);
        drive(16'h0, 8'h0);
        cyc(2);
        chk(relay_out[0], 1'b0);
        $display("delay done");
        // Aux four: slot one source 4, slot two source 5
        wr(ORL_A_SLOT0 + 8'h3, 32'h54);
        for (int f = 0; f < 5; f++)
        begin
            wr(ORL_A_FN0 + 8'h3, 32'(f));
            for (int p = 0; p < 4; p++)
            begin
                drive(16'(p) << 4, 8'h0);
                cyc(2);
                chk(relay_out[3], gate(f, p));
            end
        end
        wr(ORL_A_FN0 + 8'h3, 32'h7);
        rdc(ORL_A_FN0 + 8'h3, 32'h4);
        wr(ORL_A_DO0 + 8'h3, 32'h3);
        rdc(ORL_A_DO0 + 8'h3, 32'h1);
        $display("gates done");
        drive(16'h8, 8'h0);
        cyc(2);
        drive(16'h0, 8'h0);
        cyc(20);
        chk(relay_out[2], 1'b1);
        rdc(ORL_A_STATUS, 32'h4);
        drive(16'h0, 8'h40);
        cyc(4);
        chk(remote_reset, 1'b1);
        chk(relay_out[2], 1'b0);
        drive(16'h8, 8'h0);
        cyc(2);
        drive(16'h0, 8'h0);
        cyc(2);
        chk(relay_out[2], 1'b1);
        wr(ORL_A_RESET, 32'h1);
        cyc(2);
        chk(relay_out[2], 1'b0);
        drive(16'h8, 8'h0);
        cyc(2);
        drive(16'h0, 8'h0);
        wr(ORL_A_FN0 + 8'h2, 32'h4);
        cyc(2);
        chk(relay_out[2], 1'b0);
        wr(ORL_A_FN0 + 8'h2, 32'h0);
        $display("latch done");
        for (int r = 0; r < 12; r++)
        begin
            wr(ORL_A_ROLE0 + 8'h7, 32'(r));
            drive(16'h0, 8'h80);
            cyc(3);
            chk({bkr_52a[7], bkr_52a_any, bkr_52b_any, remote_open,
                remote_close, remote_reset, logging_trigger, demand_sync,
                set_select_one, set_select_two, breaker_failure_initiate,
                breaker_trouble}, (r == 0) ? 12'h0 : (r == 1) ? 12'hc00 :
                12'h800 >> r);
            drive(16'h0, 8'h0);
        end
        wr(ORL_A_ROLE0 + 8'h7, 32'hc);
        rdc(ORL_A_ROLE0 + 8'h7, 32'h0);
        wr(ORL_A_MON, 32'h2);
        cyc(1);
        chk({trip_coil_mon_en, close_coil_mon_en}, 2'b01);
        $display("roles done");
        drive(16'h8, 8'h0);
        cyc(2);
        drive(16'h0, 8'h0);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdc(ORL_A_FN0 + 8'h3, 32'h4);
        chk({trip_coil_mon_en, close_coil_mon_en}, 2'b10);
        chk(relay_out, 4'h0);
        $display("second reset done");
        wrap_up();
    end
    // About thirty times the expected run length
    initial
    begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule
bind orl_output_logic orl_output_logic_props u_orl_output_logic_props (
    .core_clk, .sys_rst, .contact_in, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .relay_out, .trip_coil_mon_en, .close_coil_mon_en,
    .bkr_52a, .remote_reset);
